// >>> common/ee_defines.svh
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH
// Function
// RULE_01 - answer only when type identifier matches
// RULE_02 - compare b3..b1 against chip-select pins
// RULE_03 - larger variants take high address bits
// RULE_04 - bit b0 set means read, clear write
// RULE_05 - matched select acked, mismatch goes standby
// RULE_06 - start is data falling, clock high
// RULE_07 - stop is data rising, clock high
// RULE_08 - stop after unacked read gives standby
// RULE_09 - sender releases, receiver acks ninth pulse
// RULE_10 - device samples data on clock rise
// RULE_11 - master changes data only while clock low
// RULE_12 - select byte sent most significant first
// RULE_13 - write: ack select, ack address, await data
// RULE_14 - write cycle only on tenth-slot stop
// RULE_15 - bus ignored during internal write cycle
// RULE_16 - protect seen before data: nack, unchanged
// RULE_17 - sequential read keeps clocking further bytes
// RULE_18 - random read: dummy write, repeated start
// RULE_19 - page write: sixteen bytes, one cycle
// RULE_20 - read without master ack ends in standby
// RULE_21 - read address increments, wraps to zero
// RULE_22 - capacity parameter sets depth and compares
// RULE_23 - write cycle length parameter, busy throughout

// device select byte; identifier value is arbitrary
`define EE_DEV_ID      4'h6
`define EE_ID_HI       7
`define EE_ID_LO       4
`define EE_RW_BIT      0
`define EE_CS_HI       3
`define EE_CS_LO       1
`define EE_BASE_AW     8
`define EE_FULL_AW     11
`define EE_AW_DEF      9
`define EE_PG_W        4
`define EE_PG_N        16
`define EE_ERASED      8'hFF
`define EE_WR_CYC      200
`define EE_WC_W        16
`define EE_WC_LAST     16'h0001

// bit counter: eight data rises, ninth is the ack pulse
`define EE_CNT_ACK     4'h8
`define EE_CNT_END     4'h9
`define EE_CNT_SLOT10  4'h1
`define EE_LINE_IDLE   1'b1
`define EE_OD_LOW      1'b0

// host timing: one link period is four quarters
`define EE_CLK_NS      100
`define EE_SCL_NS      800
`define EE_QTR_CYC     (`EE_SCL_NS / `EE_CLK_NS / 4)
`define EE_TQ_W        4
`define EE_Q_SET       2'h1
`define EE_Q_HIGH      2'h2
`define EE_Q_EDGE      2'h3

// host register port
`define EE_RA_W        4
`define EE_RD_W        16
`define EE_RA_CMD      4'h0
`define EE_RA_STAT     4'h4
`define EE_CMD_OP_HI   9
`define EE_CMD_OP_LO   8
`define EE_CMD_NAK     10
`define EE_STA_BUSY    0
`define EE_STA_NAK     1
`define EE_STA_RX_HI   15
`define EE_STA_RX_LO   8
`endif

// >>> common/ee_pkg.sv
package ee_pkg;
   typedef enum logic [2:0]
   {
      EE_ST_IDLE,
      EE_ST_SEL,
      EE_ST_ADDR,
      EE_ST_WDATA,
      EE_ST_RDATA,
      EE_ST_BUSY
   } ee_state_e;

   typedef enum logic [1:0]
   {
      EE_OP_START,
      EE_OP_STOP,
      EE_OP_WRITE,
      EE_OP_READ
   } ee_op_e;
endpackage

// >>> common/ee_if.sv
`timescale 1ns/1ps
interface ee_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic sda;

   // open drain with pull-up: any enabled low driver wins
   assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

   modport host
   (
      output scl,
      output m_sda_o,
      output m_sda_oe,
      input  sda
   );

   modport dev
   (
      input  scl,
      input  sda,
      output d_sda_o,
      output d_sda_oe
   );
endinterface

// >>> hdl/ee_dev.sv
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_dev
#(
   parameter int         AW     = `EE_AW_DEF,
   parameter int         WR_CYC = `EE_WR_CYC,
   parameter logic [3:0] DEV_ID = `EE_DEV_ID
)
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ce,
   ee_if.dev         bus,
   input  wire logic select_pin_0,
   input  wire logic select_pin_1,
   input  wire logic select_pin_2,
   input  wire logic write_protect_in,
   output logic      busy
);
   import ee_pkg::*;

   localparam int DEPTH = 1 << AW;
   localparam int PW    = AW - `EE_PG_W;

   logic                  scl_s1_r;
   logic                  scl_s2_r;
   logic                  scl_p_r;
   logic                  sda_s1_r;
   logic                  sda_s2_r;
   logic                  sda_p_r;
   logic                  wp_s1_r;
   logic                  wp_s2_r;
   logic [2:0]            pin_s1_r;
   logic [2:0]            pin_s2_r;
   logic                  rise;
   logic                  fall;
   logic                  start;
   logic                  stop;
   ee_state_e             st_r;
   ee_state_e             st_nxt;
   logic [3:0]            cnt_r;
   logic [3:0]            cnt_nxt;
   logic [7:0]            sh_r;
   logic [7:0]            sh_nxt;
   logic [2:0]            hi_r;
   logic [2:0]            hi_nxt;
   logic [AW-1:0]         addr_r;
   logic [AW-1:0]         addr_nxt;
   logic                  drv_r;
   logic                  drv_nxt;
   logic                  wp_r;
   logic                  wp_nxt;
   logic                  mack_r;
   logic                  mack_nxt;
   logic [`EE_PG_N-1:0]   pval_r;
   logic [`EE_PG_N-1:0]   pval_nxt;
   logic [7:0]            pbuf_r [`EE_PG_N];
   logic [7:0]            pbuf_nxt [`EE_PG_N];
   logic [`EE_WC_W-1:0]   wcnt_r;
   logic [`EE_WC_W-1:0]   wcnt_nxt;
   logic                  commit;
   logic [`EE_FULL_AW-1:0] full;
   logic [7:0]            rd_byte;
   logic [7:0]            mem_r [DEPTH];

   // RULE_01 RULE_02 RULE_22 select decode
   function automatic logic sel_match(input logic [7:0] b,
                                      input logic [2:0] pins);
      logic ok;
      ok = (b[`EE_ID_HI:`EE_ID_LO] == DEV_ID);
      for (int i = 0; i < 3; i++)
      begin
         if (AW <= `EE_BASE_AW + i)
         begin
            ok = ok && (b[`EE_CS_LO + i] == pins[i]);
         end
      end
      return ok;
   endfunction

   // all pins are foreign to clk: two flops before any use
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_s1_r <= `EE_LINE_IDLE;
         scl_s2_r <= `EE_LINE_IDLE;
         scl_p_r  <= `EE_LINE_IDLE;
         sda_s1_r <= `EE_LINE_IDLE;
         sda_s2_r <= `EE_LINE_IDLE;
         sda_p_r  <= `EE_LINE_IDLE;
         wp_s1_r  <= 1'b0;
         wp_s2_r  <= 1'b0;
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end
      else if (ce)
      begin
         scl_s1_r <= bus.scl;
         scl_s2_r <= scl_s1_r;
         scl_p_r  <= scl_s2_r;
         sda_s1_r <= bus.sda;
         sda_s2_r <= sda_s1_r;
         sda_p_r  <= sda_s2_r;
         wp_s1_r  <= write_protect_in;
         wp_s2_r  <= wp_s1_r;
         pin_s1_r <= {select_pin_2, select_pin_1, select_pin_0};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign rise  = scl_s2_r && !scl_p_r;
   assign fall  = !scl_s2_r && scl_p_r;
   // RULE_06 start detect
   assign start = scl_s2_r && scl_p_r && sda_p_r && !sda_s2_r;
   // RULE_07 stop detect
   assign stop  = scl_s2_r && scl_p_r && !sda_p_r && sda_s2_r;

   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      sh_nxt   = sh_r;
      hi_nxt   = hi_r;
      addr_nxt = addr_r;
      drv_nxt  = drv_r;
      wp_nxt   = wp_r;
      mack_nxt = mack_r;
      pval_nxt = pval_r;
      pbuf_nxt = pbuf_r;
      wcnt_nxt = wcnt_r;
      commit   = 1'b0;
      full     = {hi_r, sh_r};
      rd_byte  = mem_r[addr_r];
      if (st_r == EE_ST_BUSY)
      begin
         // RULE_15 lines ignored
         // RULE_23 busy countdown
         if (wcnt_r == `EE_WC_LAST)
         begin
            st_nxt = EE_ST_IDLE;
         end
         else
         begin
            wcnt_nxt = wcnt_r - 1'b1;
         end
      end
      else if (start)
      begin
         st_nxt   = EE_ST_SEL;
         cnt_nxt  = '0;
         drv_nxt  = 1'b0;
         wp_nxt   = wp_s2_r;
         pval_nxt = '0;
      end
      else if (stop)
      begin
         // RULE_08 RULE_20 back to standby
         drv_nxt = 1'b0;
         st_nxt  = EE_ST_IDLE;
         // RULE_14 RULE_19 tenth slot launch
         if (st_r == EE_ST_WDATA && cnt_r == `EE_CNT_SLOT10
             && (|pval_r))
         begin
            st_nxt   = EE_ST_BUSY;
            commit   = 1'b1;
            wcnt_nxt = `EE_WC_W'(WR_CYC);
         end
      end
      else if (st_r != EE_ST_IDLE)
      begin
         // RULE_16 protect window
         if (st_r == EE_ST_SEL || st_r == EE_ST_ADDR)
         begin
            wp_nxt = wp_r || wp_s2_r;
         end
         if (rise)
         begin
            cnt_nxt = cnt_r + 1'b1;
            // RULE_10 RULE_12 sample msb first
            if (cnt_r < `EE_CNT_ACK)
            begin
               if (st_r != EE_ST_RDATA)
               begin
                  sh_nxt = {sh_r[6:0], sda_s2_r};
               end
            end
            else
            begin
               mack_nxt = !sda_s2_r;
            end
         end
         if (fall)
         begin
            if (cnt_r == `EE_CNT_ACK)
            begin
               // RULE_09 RULE_05 ack slot
               unique case (st_r)
                  EE_ST_SEL:
                  begin
                     if (sel_match(sh_r, pin_s2_r))
                     begin
                        drv_nxt = 1'b1;
                     end
                     else
                     begin
                        st_nxt = EE_ST_IDLE;
                     end
                  end
                  EE_ST_ADDR:  drv_nxt = 1'b1;
                  // RULE_16 nack when protected
                  EE_ST_WDATA: drv_nxt = !wp_r;
                  EE_ST_RDATA: drv_nxt = 1'b0;
                  EE_ST_IDLE:  drv_nxt = drv_r;
                  EE_ST_BUSY:  drv_nxt = drv_r;
               endcase
            end
            else if (cnt_r == `EE_CNT_END)
            begin
               cnt_nxt = '0;
               drv_nxt = 1'b0;
               unique case (st_r)
                  EE_ST_SEL:
                  begin
                     // RULE_04 direction bit
                     if (sh_r[`EE_RW_BIT])
                     begin
                        st_nxt   = EE_ST_RDATA;
                        sh_nxt   = rd_byte;
                        drv_nxt  = !rd_byte[7];
                        addr_nxt = addr_r + 1'b1;
                     end
                     else
                     begin
                        // RULE_13 RULE_03 write path
                        st_nxt = EE_ST_ADDR;
                        hi_nxt = sh_r[`EE_CS_HI:`EE_CS_LO];
                     end
                  end
                  EE_ST_ADDR:
                  begin
                     // RULE_18 address loaded
                     addr_nxt = full[AW-1:0];
                     st_nxt   = EE_ST_WDATA;
                  end
                  EE_ST_WDATA:
                  begin
                     // RULE_19 latch, roll in page
                     if (!wp_r)
                     begin
                        pbuf_nxt[addr_r[`EE_PG_W-1:0]] = sh_r;
                        pval_nxt[addr_r[`EE_PG_W-1:0]] = 1'b1;
                        addr_nxt = {addr_r[AW-1:`EE_PG_W],
                                    `EE_PG_W'(addr_r[`EE_PG_W-1:0] + 1'b1)};
                     end
                  end
                  EE_ST_RDATA:
                  begin
                     // RULE_17 RULE_21 next byte
                     if (mack_r)
                     begin
                        sh_nxt   = rd_byte;
                        drv_nxt  = !rd_byte[7];
                        addr_nxt = addr_r + 1'b1;
                     end
                     else
                     begin
                        // RULE_20 no ack, standby
                        st_nxt = EE_ST_IDLE;
                     end
                  end
                  EE_ST_IDLE:  st_nxt = st_r;
                  EE_ST_BUSY:  st_nxt = st_r;
               endcase
            end
            else if (st_r == EE_ST_RDATA)
            begin
               sh_nxt  = {sh_r[6:0], 1'b0};
               drv_nxt = !sh_r[6];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r   <= EE_ST_IDLE;
         cnt_r  <= '0;
         sh_r   <= '0;
         hi_r   <= '0;
         addr_r <= '0;
         drv_r  <= 1'b0;
         wp_r   <= 1'b0;
         mack_r <= 1'b0;
         pval_r <= '0;
         pbuf_r <= '{default: '0};
         wcnt_r <= '0;
      end
      else if (ce)
      begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         sh_r   <= sh_nxt;
         hi_r   <= hi_nxt;
         addr_r <= addr_nxt;
         drv_r  <= drv_nxt;
         wp_r   <= wp_nxt;
         mack_r <= mack_nxt;
         pval_r <= pval_nxt;
         pbuf_r <= pbuf_nxt;
         wcnt_r <= wcnt_nxt;
      end
   end

   // all latched bytes of the page are written at once, so a partial page costs
   // the same cycle as a full one
   for (genvar j = 0; j < DEPTH; j++)
   begin : g_mem
      localparam logic [`EE_PG_W-1:0] LO = `EE_PG_W'(j);
      localparam logic [PW-1:0]       PG = PW'(j >> `EE_PG_W);
      always_ff @(posedge clk or negedge resetn)
      begin
         if (!resetn)
         begin
            mem_r[j] <= `EE_ERASED;
         end
         else if (ce && commit && pval_r[LO]
                  && addr_r[AW-1:`EE_PG_W] == PG)
         begin
            mem_r[j] <= pbuf_r[LO];
         end
      end
   end

   assign bus.d_sda_oe = drv_r;
   assign bus.d_sda_o  = `EE_OD_LOW;
   // RULE_23 busy flag
   assign busy         = (st_r == EE_ST_BUSY);
endmodule

// >>> hdl/ee_host.sv
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_host
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             ce,
   ee_if.host                    bus,
   input  wire logic [`EE_RA_W-1:0] reg_addr,
   input  wire logic [`EE_RD_W-1:0] reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [`EE_RD_W-1:0]   reg_rdata
);
   import ee_pkg::*;

   logic                  sda_s1_r;
   logic                  sda_s2_r;
   logic                  busy_r;
   logic                  busy_nxt;
   ee_op_e                op_r;
   ee_op_e                op_nxt;
   logic [1:0]            q_r;
   logic [1:0]            q_nxt;
   logic [`EE_TQ_W-1:0]   tq_r;
   logic [`EE_TQ_W-1:0]   tq_nxt;
   logic [3:0]            bit_r;
   logic [3:0]            bit_nxt;
   logic [3:0]            last_bit;
   logic [7:0]            sh_r;
   logic [7:0]            sh_nxt;
   logic                  nakc_r;
   logic                  nakc_nxt;
   logic                  lo_r;
   logic                  lo_nxt;
   logic                  scl_r;
   logic                  scl_nxt;
   logic [7:0]            rx_r;
   logic [7:0]            rx_nxt;
   logic                  nak_r;
   logic                  nak_nxt;
   logic [`EE_RD_W-1:0]   rdata_r;
   logic [`EE_RD_W-1:0]   rdata_nxt;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sda_s1_r <= `EE_LINE_IDLE;
         sda_s2_r <= `EE_LINE_IDLE;
      end
      else if (ce)
      begin
         sda_s1_r <= bus.sda;
         sda_s2_r <= sda_s1_r;
      end
   end

   always_comb
   begin
      busy_nxt  = busy_r;
      op_nxt    = op_r;
      q_nxt     = q_r;
      tq_nxt    = tq_r;
      bit_nxt   = bit_r;
      sh_nxt    = sh_r;
      nakc_nxt  = nakc_r;
      lo_nxt    = lo_r;
      scl_nxt   = scl_r;
      rx_nxt    = rx_r;
      nak_nxt   = nak_r;
      rdata_nxt = '0;
      last_bit  = (op_r == EE_OP_WRITE || op_r == EE_OP_READ)
                  ? `EE_CNT_ACK : '0;
      if (reg_rd && reg_addr == `EE_RA_STAT)
      begin
         rdata_nxt[`EE_STA_BUSY] = busy_r;
         rdata_nxt[`EE_STA_NAK]  = nak_r;
         rdata_nxt[`EE_STA_RX_HI:`EE_STA_RX_LO] = rx_r;
      end
      if (!busy_r)
      begin
         // commands while busy are dropped, so poll status first
         if (reg_wr && reg_addr == `EE_RA_CMD)
         begin
            busy_nxt = 1'b1;
            op_nxt   = ee_op_e'(reg_wdata[`EE_CMD_OP_HI:`EE_CMD_OP_LO]);
            sh_nxt   = reg_wdata[7:0];
            nakc_nxt = reg_wdata[`EE_CMD_NAK];
            q_nxt    = '0;
            tq_nxt   = '0;
            bit_nxt  = '0;
            scl_nxt  = 1'b0;
         end
      end
      else if (tq_r != `EE_TQ_W'(`EE_QTR_CYC - 1))
      begin
         tq_nxt = tq_r + 1'b1;
      end
      else
      begin
         tq_nxt = '0;
         if (q_r == `EE_Q_EDGE)
         begin
            if (op_r == EE_OP_READ && bit_r < `EE_CNT_ACK)
            begin
               sh_nxt = {sh_r[6:0], sda_s2_r};
            end
            else if (op_r == EE_OP_WRITE)
            begin
               // RULE_12 msb first
               if (bit_r < `EE_CNT_ACK)
               begin
                  sh_nxt = {sh_r[6:0], 1'b0};
               end
               else
               begin
                  nak_nxt = sda_s2_r;
               end
            end
            if (bit_r == last_bit)
            begin
               busy_nxt = 1'b0;
               if (op_r == EE_OP_READ)
               begin
                  rx_nxt = sh_r;
               end
            end
            else
            begin
               bit_nxt = bit_r + 1'b1;
               q_nxt   = '0;
               scl_nxt = 1'b0;
            end
         end
         else
         begin
            q_nxt   = q_r + 1'b1;
            scl_nxt = (q_nxt >= `EE_Q_HIGH);
            // RULE_11 byte data moves with clock low; start and stop move it under high clock
            unique case (op_r)
               EE_OP_START:
               begin
                  // RULE_06 RULE_18 release, then fall under high clock
                  if (q_nxt == `EE_Q_SET)
                     lo_nxt = 1'b0;
                  else if (q_nxt == `EE_Q_EDGE)
                     lo_nxt = 1'b1;
               end
               EE_OP_STOP:
               begin
                  // RULE_07 RULE_08 low, then rise under high clock
                  if (q_nxt == `EE_Q_SET)
                     lo_nxt = 1'b1;
                  else if (q_nxt == `EE_Q_EDGE)
                     lo_nxt = 1'b0;
               end
               EE_OP_WRITE:
               begin
                  // RULE_09 release for the ninth pulse
                  if (q_nxt == `EE_Q_SET)
                     lo_nxt = (bit_r < `EE_CNT_ACK) && !sh_r[7];
               end
               EE_OP_READ:
               begin
                  // RULE_17 RULE_20 ack keeps stream
                  if (q_nxt == `EE_Q_SET)
                     lo_nxt = (bit_r == `EE_CNT_ACK) && !nakc_r;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busy_r  <= 1'b0;
         op_r    <= EE_OP_START;
         q_r     <= '0;
         tq_r    <= '0;
         bit_r   <= '0;
         sh_r    <= '0;
         nakc_r  <= 1'b0;
         lo_r    <= 1'b0;
         scl_r   <= `EE_LINE_IDLE;
         rx_r    <= '0;
         nak_r   <= 1'b0;
         rdata_r <= '0;
      end
      else if (ce)
      begin
         busy_r  <= busy_nxt;
         op_r    <= op_nxt;
         q_r     <= q_nxt;
         tq_r    <= tq_nxt;
         bit_r   <= bit_nxt;
         sh_r    <= sh_nxt;
         nakc_r  <= nakc_nxt;
         lo_r    <= lo_nxt;
         scl_r   <= scl_nxt;
         rx_r    <= rx_nxt;
         nak_r   <= nak_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign bus.scl      = scl_r;
   assign bus.m_sda_oe = lo_r;
   assign bus.m_sda_o  = `EE_OD_LOW;
   assign reg_rdata    = rdata_r;
endmodule

// >>> sim/ee_checker.sv
`timescale 1ns/1ps
module ee_checker
#(
   parameter int WR_CYC = 200
)
(
   input logic clk,
   input logic resetn,
   input logic scl,
   input logic sda,
   input logic m_sda_oe,
   input logic d_sda_oe,
   input logic busy
);
   logic [15:0] run_r;
   logic [15:0] run_nxt;
   logic [3:0]  since_r;
   logic [3:0]  since_nxt;
   logic        sda_q_r;
   logic        stop_seen;

   // previous sample kept by hand: no sampled-value call outside properties
   assign stop_seen = scl && sda && !sda_q_r;

   always_comb
   begin
      run_nxt = busy ? run_r + 16'h0001 : 16'h0000;
      since_nxt = (since_r == 4'hF) ? since_r : since_r + 4'h1;
      if (stop_seen)
         since_nxt = 4'h0;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         run_r   <= 16'h0000;
         since_r <= 4'hF;
         sda_q_r <= 1'b1;
      end
      else
      begin
         run_r   <= run_nxt;
         since_r <= since_nxt;
         sda_q_r <= sda;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence start_s;
      scl && $past(scl) && $fell(sda);
   endsequence

   sequence stop_s;
      scl && $past(scl) && $rose(sda);
   endsequence

   quiet_busy_a: assert property (busy |-> !d_sda_oe)
      else $error("device drives data while busy");
   busy_len_a: assert property ($fell(busy) |->
      (run_r >= WR_CYC && run_r <= WR_CYC + 2))
      else $error("busy span differs from write cycle length");
   launch_stop_a: assert property ($rose(busy) |-> since_r <= 4'h8)
      else $error("write cycle began without a stop");
   ack_low_a: assert property ($changed(d_sda_oe) |-> !scl)
      else $error("device data changed with clock high");
   start_quiet_a: assert property (start_s |=> !d_sda_oe [*8])
      else $error("device drives data right after start");
   stop_quiet_a: assert property (stop_s |=> !d_sda_oe [*8])
      else $error("device drives data after stop");
   one_driver_a: assert property ((d_sda_oe && scl) |-> !m_sda_oe)
      else $error("both ends drive data");
   host_hold_a: assert property ($rose(scl) |-> ##1 $stable(m_sda_oe))
      else $error("host data moved in high clock phase");
endmodule

// >>> sim/serial_eeprom_i2c_slave_bench.sv
`timescale 1ns/1ps
`include "ee_defines.svh"
module serial_eeprom_i2c_slave_bench;
   import ee_pkg::*;
   localparam int WCYC = 150;
   logic        clk;
   logic        resetn;
   logic        ce;
   logic        write_protect_in;
   logic        busy;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] st;
   logic [2:0]  acks;
   logic [7:0]  d;
   logic [7:0]  tab [4];
   int          err_total;
   int          checks_done;
   int          n;

   ee_if ee_if_inst();
   ee_dev #(.AW(9), .WR_CYC(WCYC)) ee_dev_inst
   (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .bus(ee_if_inst),
      .select_pin_0(1'b1),
      .select_pin_1(1'b0),
      .select_pin_2(1'b1),
      .write_protect_in(write_protect_in),
      .busy(busy)
   );
   ee_host ee_host_inst
   (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .bus(ee_if_inst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata)
   );
   ee_checker #(.WR_CYC(WCYC)) ee_checker_inst
   (
      .clk(clk),
      .resetn(resetn),
      .scl(ee_if_inst.scl),
      .sda(ee_if_inst.sda),
      .m_sda_oe(ee_if_inst.m_sda_oe),
      .d_sda_oe(ee_if_inst.d_sda_oe),
      .busy(busy)
   );

   always #50 clk = ~clk;

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic rw(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rr(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask

   // host ignores commands while busy, so every op polls to the end
   task automatic xfer(input ee_op_e op, input logic [7:0] b,
                       input logic nak);
      rw(`EE_RA_CMD, {5'h00, nak, op, b});
      n = 0;
      do
      begin
         rr(`EE_RA_STAT, st);
         n++;
      end
      while (st[`EE_STA_BUSY] !== 1'b0 && n < 200);
      if (n == 200)
      begin
         err_total++;
         $display("wrong value at %0t: host stuck busy", $time);
      end
   endtask

   function automatic logic [7:0] sel(input logic a8, input logic dir);
      return {`EE_DEV_ID, 2'b10, a8, dir};
   endfunction

   task automatic stp();
      xfer(EE_OP_STOP, 8'h00, 1'b0);
   endtask

   task automatic head(input logic [8:0] a);
      xfer(EE_OP_START, 8'h00, 1'b0);
      xfer(EE_OP_WRITE, sel(a[8], 1'b0), 1'b0);
      acks[2] = st[`EE_STA_NAK];
      xfer(EE_OP_WRITE, a[7:0], 1'b0);
      acks[1] = st[`EE_STA_NAK];
   endtask

   task automatic put(input logic [8:0] a, input logic [7:0] v);
      head(a);
      xfer(EE_OP_WRITE, v, 1'b0);
      acks[0] = st[`EE_STA_NAK];
      stp();
   endtask

   task automatic get(input logic [8:0] a, input logic nak,
                      output logic [7:0] v);
      head(a);
      xfer(EE_OP_START, 8'h00, 1'b0);
      xfer(EE_OP_WRITE, sel(a[8], 1'b1), 1'b0);
      acks[0] = st[`EE_STA_NAK];
      xfer(EE_OP_READ, 8'h00, nak);
      v = st[15:8];
   endtask

   task automatic settle();
      n = 0;
      while (busy !== 1'b0 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
   endtask

   // about ten times the expected run
   initial
   begin
      #4000000;
      err_total++;
      conclude();
   end

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      ce = 1'b1;
      write_protect_in = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_total = 0;
      checks_done = 0;
      tab = '{{`EE_DEV_ID ^ 4'h8, 4'h8}, {`EE_DEV_ID, 4'h0},
              {`EE_DEV_ID, 4'hC}, {`EE_DEV_ID, 4'h8}};
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      put(9'h1A5, 8'h3C);
      chk(acks, 3'h0);
      chk(busy, 1'b1);
      // poll by select while the write cycle runs
      xfer(EE_OP_START, 8'h00, 1'b0);
      xfer(EE_OP_WRITE, sel(1'b1, 1'b0), 1'b0);
      chk(st[`EE_STA_NAK], 1'b1);
      stp();
      settle();
      chk(busy, 1'b0);
      rr(4'h8, st);
      chk(st, 16'h0000);
      $display("write test done");
      get(9'h1A5, 1'b1, d);
      chk(acks, 3'h0);
      chk(d, 8'h3C);
      stp();
      get(9'h0A5, 1'b1, d);
      chk(d, 8'hFF);
      stp();
      $display("read test done");
      for (int i = 0; i < 4; i++)
      begin
         xfer(EE_OP_START, 8'h00, 1'b0);
         xfer(EE_OP_WRITE, tab[i], 1'b0);
         chk(st[`EE_STA_NAK], i < 3);
         stp();
      end
      chk(busy, 1'b0);
      xfer(EE_OP_WRITE, sel(1'b0, 1'b0), 1'b0);
      chk(st[`EE_STA_NAK], 1'b1);
      stp();
      $display("select test done");
      @(posedge clk);
      write_protect_in <= 1'b1;
      head(9'h0A5);
      @(posedge clk);
      write_protect_in <= 1'b0;
      chk(acks[2:1], 2'h0);
      xfer(EE_OP_WRITE, 8'h11, 1'b0);
      chk(st[`EE_STA_NAK], 1'b1);
      stp();
      settle();
      get(9'h0A5, 1'b1, d);
      chk(d, 8'hFF);
      stp();
      $display("protect test done");
      head(9'h0F0);
      xfer(EE_OP_WRITE, 8'h77, 1'b0);
      xfer(EE_OP_WRITE, 8'h88, 1'b0);
      stp();
      settle();
      get(9'h0F0, 1'b0, d);
      chk(d, 8'h77);
      xfer(EE_OP_READ, 8'h00, 1'b1);
      chk(st[15:8], 8'h88);
      stp();
      $display("page test done");
      put(9'h000, 8'h5A);
      settle();
      get(9'h1FF, 1'b0, d);
      chk(d, 8'hFF);
      xfer(EE_OP_READ, 8'h00, 1'b1);
      chk(st[15:8], 8'h5A);
      stp();
      $display("wrap test done");
      conclude();
   end
endmodule
